// [sim/flash_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00A5,
  parameter logic [15:0] PART_CODE  = 16'h005A
) (
  input  wire logic        i_reset_n,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic [2:0]  i_mode,
  input  wire logic        i_plane,
  output logic      [15:0] o_dq
);
  logic [15:0] mem [16];
  logic [15:0] d;
  logic [15:0] last_q;
  logic [4:0]  esec_q;
  logic        id_q;
  logic        w7_q;
  logic        tog_q = 1'b0;
  logic        busy;
  logic        insec;
  logic        rd_n;
  // One advance per read access, whichever strobe opens it
  assign rd_n = i_ce_n | i_oe_n;
  always @(negedge rd_n) tog_q <= ~tog_q;
  always @(posedge i_we_n or negedge i_reset_n) begin
    if (!i_reset_n) begin
      id_q <= 1'b0;
    end else if (!i_ce_n) begin
      case (i_dq[7:0])
        8'h90: id_q <= 1'b1;
        8'hF0: id_q <= 1'b0;
        8'h30: esec_q <= i_addr[19:15];
        default: begin
          mem[i_addr[3:0]] <= i_dq;
          w7_q <= i_dq[7];
        end
      endcase
    end
  end
  always_comb begin
    busy = (i_addr[19:18] != 2'b00) == i_plane;
    insec = i_addr[19:15] == esec_q;
    d = mem[i_addr[3:0]];
    // Codes only answer with every upper address line low
    if (id_q && i_addr[19:1] == 19'h0) begin
      d = i_addr[0] ? PART_CODE : MAKER_CODE;
    end
    if (i_mode >= 3'd3 && insec) begin
      d[7] = 1'b1;
      d[6] = 1'b1;
      d[2] = tog_q;
    end else if (i_mode == 3'd1 && busy) begin
      d[7] = ~w7_q;
      d[6] = tog_q;
      d[2] = 1'b1;
    end else if ((i_mode == 3'd2 || i_mode == 3'd4) && busy) begin
      d[7] = i_mode == 3'd4 ? ~w7_q : 1'b0;
      d[6] = tog_q;
      d[2] = tog_q;
    end
  end
  // A released bus shows the inverse of its last value, never a lucky match
  always @(i_ce_n, i_oe_n, d) if (!i_ce_n && !i_oe_n) last_q = d;
  assign o_dq = (!i_ce_n && !i_oe_n) ? d : ~last_q;
endmodule
`default_nettype wire

// [sim/flash_status_host_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_status_host_assertions #(
  parameter int POLL_LIMIT = 200
) (
  input wire logic                              i_mclk,
  input wire logic                              i_rst,
  input wire logic                              i_cmd_valid,
  input wire logic                              o_cmd_ready,
  input wire logic                              o_done,
  input wire logic                              o_flash_reset_n,
  input wire logic                              o_ce_n,
  input wire logic                              o_oe_n,
  input wire logic                              o_we_n,
  input wire logic [flash_host_pkg::ADDR_W-1:0] o_addr,
  input wire logic                              o_dq_oe
);
  import flash_host_pkg::*;
  localparam int DONE_MAX = POLL_LIMIT + 400;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  write_oe_high_a: assert property (!o_we_n |-> o_oe_n && !o_ce_n)
    else $error("output gate low or select high in write pulse");
  dq_drive_safe_a: assert property (o_dq_oe |-> o_oe_n && !o_ce_n)
    else $error("data driven outside a write cycle");
  we_pulse_width_a: assert property ($fell(o_we_n) |-> !o_we_n [*8])
    else $error("write pulse too short");
  read_strobe_a: assert property (!o_oe_n |-> !o_ce_n && o_we_n)
    else $error("output gate low without select");
  oe_high_gap_a: assert property ($rose(o_oe_n) |-> o_oe_n [*8])
    else $error("output gate high pulse too short");
  addr_hold_a: assert property (!o_ce_n && !$past(o_ce_n) |-> $stable(o_addr))
    else $error("address moved inside a cycle");
  reset_quiet_a: assert property (!o_flash_reset_n |-> !o_cmd_ready && o_ce_n)
    else $error("activity while flash held in reset");
  done_bound_a: assert property (i_cmd_valid && o_cmd_ready |=> ##[1:DONE_MAX] o_done)
    else $error("request never completed");
  done_pulse_a: assert property (o_done |-> o_cmd_ready ##1 !o_done)
    else $error("done not a single pulse with ready");
  cover property ($fell(o_we_n));
  cover property (o_done);
  cover property ($rose(o_flash_reset_n));
endmodule
bind flash_status_host flash_status_host_assertions #(.POLL_LIMIT(POLL_LIMIT)) chk (
  .i_mclk, .i_rst, .i_cmd_valid, .o_cmd_ready, .o_done, .o_flash_reset_n,
  .o_ce_n, .o_oe_n, .o_we_n, .o_addr, .o_dq_oe
);
`default_nettype wire

// [sim/tb_flash_status_host.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_flash_status_host;
  import flash_host_pkg::*;
  localparam logic [15:0] MAKER = 16'h00A5; // Arbitrary code
  localparam logic [15:0] PART  = 16'h005A; // Arbitrary code
  localparam logic [17:0] MD    = 18'h0FFFF;
  logic              i_mclk = 1'b0;
  logic              i_rst = 1'b1;
  logic              i_cmd_valid = 1'b0;
  logic              plane = 1'b0;
  logic [2:0]        mode = 3'h0;
  op_t               i_cmd_op = OP_READ;
  logic [ADDR_W-1:0] i_cmd_addr = 20'h0;
  logic [ADDR_W-1:0] o_addr;
  logic [DATA_W-1:0] i_cmd_wdata = 16'h0;
  logic [DATA_W-1:0] v, nv, dev_dq, i_dq, o_dq, o_rdata;
  logic              o_cmd_ready, o_done, o_timeout, o_sector_toggled;
  logic              o_flash_reset_n, o_ce_n, o_oe_n, o_we_n, o_dq_oe;
  logic [17:0]       exp_q[$];
  logic [17:0]       msk_q[$];
  logic [17:0]       e, m;
  int                num_errors = 0;
  int                tests_run = 0;
  int                seed = 43;
  always #5 i_mclk = ~i_mclk;
  assign i_dq = o_dq_oe ? o_dq : dev_dq;
  flash_status_host #(.POLL_LIMIT(200)) dut (.i_mclk, .i_rst, .i_cmd_valid, .i_cmd_op,
    .i_cmd_addr, .i_cmd_wdata, .o_cmd_ready, .o_done, .o_timeout, .o_sector_toggled,
    .o_rdata, .o_flash_reset_n, .o_ce_n, .o_oe_n, .o_we_n, .o_addr, .i_dq, .o_dq, .o_dq_oe);
  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dev (.i_reset_n(o_flash_reset_n),
    .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_addr(o_addr), .i_dq(o_dq),
    .i_mode(mode), .i_plane(plane), .o_dq(dev_dq));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    for (n = 0; n < 3000 && o_cmd_ready !== 1'b1; n++) @(negedge i_mclk);
    if (n == 3000) begin
      num_errors++;
      $display("[ERR] o_cmd_ready exp 1 seen %b", o_cmd_ready);
      print_verdict();
    end
  endtask
  // Mask zero marks a completion that is only consumed, not compared
  task automatic op(input op_t k, input logic [19:0] a, input logic [15:0] w,
                    input logic [17:0] ex, input logic [17:0] mk);
    wait_ready();
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    i_cmd_op = k;
    i_cmd_addr = a;
    i_cmd_wdata = w;
    i_cmd_valid = 1'b1;
    @(negedge i_mclk);
    i_cmd_valid = 1'b0;
  endtask
  task automatic st(input logic [2:0] md, input logic pl, input op_t k, input logic [19:0] a,
                    input logic [15:0] w, input logic [17:0] ex, input logic [17:0] mk);
    wait_ready();
    mode = md;
    plane = pl;
    op(k, a, w, ex, mk);
  endtask
  always @(negedge i_mclk) if (o_done === 1'b1) begin
    e = exp_q.size() > 0 ? exp_q.pop_front() : 18'h0;
    m = msk_q.size() > 0 ? msk_q.pop_front() : 18'h3FFFF;
    if (m !== 18'h0) begin
      tests_run++;
      if ((({o_sector_toggled, o_timeout, o_rdata} ^ e) & m) !== 18'h0) begin
        num_errors++;
        $display("[ERR] result exp %h seen %h mask %h", e,
                 {o_sector_toggled, o_timeout, o_rdata}, m);
      end
    end
  end
  initial begin
    v = $random(seed);
    v[0] = 1'b1;
    nv = v ^ 16'h0080;
    repeat (12) @(negedge i_mclk);
    i_rst = 1'b0;
    op(OP_WRITE, 20'h00003, v, 18'h0, 18'h0);
    op(OP_READ, 20'h00003, 16'h0, {2'b00, v}, MD);
    op(OP_CMD, 20'hF5555, 16'hA590, 18'h0, 18'h0);
    op(OP_ID_READ, 20'hABCD0, 16'h0, {2'b00, MAKER}, MD);
    op(OP_ID_READ, 20'h54321, 16'h0, {2'b00, PART}, MD);
    op(OP_CMD, 20'h05555, 16'h00F0, 18'h0, 18'h0);
    op(OP_READ, 20'h00003, 16'h0, {2'b00, v}, MD);
    op(OP_CMD, 20'h05555, 16'h0090, 18'h0, 18'h0);
    wait_ready();
    i_rst = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    op(OP_READ, 20'h00003, 16'h0, {2'b00, v}, MD);
    op(OP_WRITE, 20'h48003, 16'h0030, 18'h0, 18'h0);
    st(3'h1, 1'b0, OP_TOGGLE_POLL, 20'h00003, 16'h0, {2'b01, nv | 16'h0004}, 18'h10084);
    st(3'h1, 1'b0, OP_READ, 20'h80003, 16'h0, {2'b00, v}, MD);
    st(3'h1, 1'b1, OP_DATA_POLL, 20'h80003, v, {2'b01, nv | 16'h0004}, 18'h10084);
    st(3'h1, 1'b1, OP_READ, 20'h00003, 16'h0, {2'b00, v}, MD);
    st(3'h2, 1'b1, OP_DATA_POLL, 20'h80003, 16'h0080, 18'h10000, 18'h10080);
    st(3'h2, 1'b1, OP_READ, 20'h00003, 16'h0, {2'b00, v}, MD);
    st(3'h3, 1'b1, OP_TOGGLE_POLL, 20'h48003, 16'h0, 18'h200C0, 18'h300C0);
    st(3'h3, 1'b1, OP_READ, 20'h88003, 16'h0, {2'b00, v}, MD);
    st(3'h4, 1'b1, OP_TOGGLE_POLL, 20'h88003, 16'h0, {2'b11, nv}, 18'h30080);
    st(3'h4, 1'b1, OP_READ, 20'h00003, 16'h0, {2'b00, v}, MD);
    st(3'h0, 1'b0, OP_TOGGLE_POLL, 20'h00003, 16'h0, {2'b00, v}, 18'h3FFFF);
    wait_ready();
    repeat (2) @(negedge i_mclk);
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("[ERR] pending results exp 0 seen %0d", exp_q.size());
    end
    print_verdict();
  end
endmodule
`default_nettype wire

// [verilog/flash_bus_cycle.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle (
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst,
  flash_cycle_if.eng                         cyc,
  input  wire logic [flash_host_pkg::DATA_W-1:0] i_dq,
  output logic                               o_ce_n,
  output logic                               o_oe_n,
  output logic                               o_we_n,
  output logic [flash_host_pkg::ADDR_W-1:0]  o_addr,
  output logic [flash_host_pkg::DATA_W-1:0]  o_dq,
  output logic                               o_dq_oe
);
  import flash_host_pkg::*;

  typedef enum {E_IDLE, E_SETUP, E_STROBE, E_HOLD, E_REC} phase_t;

  phase_t            st_q, st_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic              wr_q, wr_d, ce_q, ce_d, oe_q, oe_d, we_q, we_d;
  logic              dqoe_q, dqoe_d, ack_q, ack_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] dq_q, dq_d, rdata_q, rdata_d;
  logic [DATA_W-1:0] s1_q, s2_q, s3_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    ce_d = ce_q;
    oe_d = oe_q;
    we_d = we_q;
    dqoe_d = dqoe_q;
    addr_d = addr_q;
    dq_d = dq_q;
    rdata_d = rdata_q;
    ack_d = 1'b0;
    case (st_q)
      E_IDLE: begin
        if (cyc.req && !ack_q) begin
          addr_d = cyc.addr;
          dq_d = cyc.wdata;
          wr_d = cyc.wr;
          dqoe_d = cyc.wr;
          ce_d = 1'b0;
          cnt_d = CNT_W'(AS_CYC - 1);
          st_d = E_SETUP;
        end
      end
      E_SETUP: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (wr_q) begin
          we_d = 1'b0;
          cnt_d = CNT_W'(WP_CYC - 1);
          st_d = E_STROBE;
        end else begin
          oe_d = 1'b0;
          cnt_d = CNT_W'(ACC_CYC + SYNC_CYC - 1);
          st_d = E_STROBE;
        end
      end
      E_STROBE: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (wr_q) begin
          we_d = 1'b1;
          cnt_d = CNT_W'(DH_CYC - 1);
          st_d = E_HOLD;
        end else if (s2_q == s3_q) begin
          rdata_d = s3_q;
          oe_d = 1'b1;
          ce_d = 1'b1;
          // Both strobes stay high long enough to advance the toggle flag
          cnt_d = CNT_W'(OEHP_CYC - 1);
          st_d = E_REC;
        end
      end
      E_HOLD: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          dqoe_d = 1'b0;
          ce_d = 1'b1;
          cnt_d = CNT_W'(OEHP_CYC - 1);
          st_d = E_REC;
        end
      end
      E_REC: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          ack_d = 1'b1;
          st_d = E_IDLE;
        end
      end
      default: st_d = E_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= E_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      ce_q <= 1'b1;
      oe_q <= 1'b1;
      we_q <= 1'b1;
      dqoe_q <= 1'b0;
      ack_q <= 1'b0;
      addr_q <= '0;
      dq_q <= '0;
      rdata_q <= '0;
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      ce_q <= ce_d;
      oe_q <= oe_d;
      we_q <= we_d;
      dqoe_q <= dqoe_d;
      ack_q <= ack_d;
      addr_q <= addr_d;
      dq_q <= dq_d;
      rdata_q <= rdata_d;
      s1_q <= i_dq;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign cyc.ack = ack_q;
  assign cyc.rdata = rdata_q;
  assign o_ce_n = ce_q;
  assign o_oe_n = oe_q;
  assign o_we_n = we_q;
  assign o_addr = addr_q;
  assign o_dq = dq_q;
  assign o_dq_oe = dqoe_q;
endmodule
`default_nettype wire

// [verilog/flash_cycle_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface flash_cycle_if;
  import flash_host_pkg::*;
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              ack;
  logic [DATA_W-1:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input ack, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface
`default_nettype wire

// [verilog/flash_host_pkg.sv]
`default_nettype none
package flash_host_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CLK_NS = 10;

  // Pin timing in ns, the poll limit in ms, and the least cycle counts derived from them
  localparam int T_AS_NS   = 10;
  localparam int T_WP_NS   = 100;
  localparam int T_DH_NS   = 10;
  localparam int T_ACC_NS  = 90;
  localparam int T_OEHP_NS = 150;
  localparam int T_RO_NS   = 800;
  localparam int T_RST_NS  = 500;
  localparam int T_POLL_LIMIT_MS = 1000;
  localparam int AS_CYC   = (T_AS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int DH_CYC   = (T_DH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int OEHP_CYC = (T_OEHP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RO_CYC   = (T_RO_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC  = (T_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int POLL_LIMIT_CYC = T_POLL_LIMIT_MS * (1000000 / CLK_NS);
  localparam int SYNC_CYC = 2;
  localparam int CNT_W    = 8;

  // Status and command field positions and widths
  localparam int DATA_POLL_BIT           = 7;
  localparam int TOGGLE_FLAG_BIT         = 6;
  localparam int ERASE_SECTOR_TOGGLE_BIT = 2;
  localparam int ID_SELECT_ADDR_BIT      = 0;
  localparam int CMD_ADDR_BITS           = 16;
  localparam int CMD_DATA_BITS           = 8;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_CMD,
    OP_ID_READ,
    OP_TOGGLE_POLL,
    OP_DATA_POLL
  } op_t;
endpackage
`default_nettype wire

// [verilog/flash_status_host.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_status_host #(
  parameter int POLL_LIMIT = flash_host_pkg::POLL_LIMIT_CYC
) (
  input  wire logic                              i_mclk,
  input  wire logic                              i_rst,
  input  wire logic                              i_cmd_valid,
  input  wire flash_host_pkg::op_t               i_cmd_op,
  input  wire logic [flash_host_pkg::ADDR_W-1:0] i_cmd_addr,
  input  wire logic [flash_host_pkg::DATA_W-1:0] i_cmd_wdata,
  output logic                                   o_cmd_ready,
  output logic                                   o_done,
  output logic                                   o_timeout,
  output logic                                   o_sector_toggled,
  output logic [flash_host_pkg::DATA_W-1:0]      o_rdata,
  output logic                                   o_flash_reset_n,
  output logic                                   o_ce_n,
  output logic                                   o_oe_n,
  output logic                                   o_we_n,
  output logic [flash_host_pkg::ADDR_W-1:0]      o_addr,
  input  wire logic [flash_host_pkg::DATA_W-1:0] i_dq,
  output logic [flash_host_pkg::DATA_W-1:0]      o_dq,
  output logic                                   o_dq_oe
);
  import flash_host_pkg::*;

  if (POLL_LIMIT < 2) begin : g_poll_limit_check
    $error("POLL_LIMIT must be at least 2");
  end

  typedef enum {M_RST, M_BOOT, M_IDLE, M_BUSY} mstate_t;

  flash_cycle_if cyc ();

  mstate_t           st_q, st_d;
  logic [31:0]       tmr_q, tmr_d;
  op_t               op_q, op_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d, prev_q, prev_d, rdata_q, rdata_d;
  logic              req_q, req_d, wr_q, wr_d, first_q, first_d;
  logic              ready_q, ready_d, done_q, done_d, tout_q, tout_d;
  logic              stog_q, stog_d, frst_n_q, frst_n_d;
  logic              settled;

  flash_bus_cycle u_cycle (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .cyc     (cyc),
    .i_dq    (i_dq),
    .o_ce_n  (o_ce_n),
    .o_oe_n  (o_oe_n),
    .o_we_n  (o_we_n),
    .o_addr  (o_addr),
    .o_dq    (o_dq),
    .o_dq_oe (o_dq_oe)
  );

  assign cyc.req = req_q;
  assign cyc.wr = wr_q;
  assign cyc.addr = addr_q;
  assign cyc.wdata = wdata_q;

  // A toggle poll ends when bit 6 matches across two reads, a data poll when bit 7 matches the written data
  always_comb begin
    settled = 1'b0;
    if (op_q == OP_TOGGLE_POLL) begin
      settled = !first_q &&
                (cyc.rdata[TOGGLE_FLAG_BIT] == prev_q[TOGGLE_FLAG_BIT]);
    end else begin
      settled = cyc.rdata[DATA_POLL_BIT] == wdata_q[DATA_POLL_BIT];
    end
  end

  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    op_d = op_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    prev_d = prev_q;
    rdata_d = rdata_q;
    req_d = req_q;
    wr_d = wr_q;
    first_d = first_q;
    ready_d = ready_q;
    done_d = 1'b0;
    tout_d = tout_q;
    stog_d = stog_q;
    frst_n_d = frst_n_q;
    case (st_q)
      M_RST: begin
        tmr_d = tmr_q + 1'b1;
        if (tmr_q == 32'(RST_CYC - 1)) begin
          // Pulsing the reset pin leaves the device in normal read mode
          frst_n_d = 1'b1;
          tmr_d = '0;
          st_d = M_BOOT;
        end
      end
      M_BOOT: begin
        tmr_d = tmr_q + 1'b1;
        if (tmr_q == 32'(RO_CYC - 1)) begin
          ready_d = 1'b1;
          st_d = M_IDLE;
        end
      end
      M_IDLE: begin
        if (i_cmd_valid) begin
          op_d = i_cmd_op;
          // Plain writes keep every address line, so an erase can name its sector
          addr_d = i_cmd_addr;
          wdata_d = i_cmd_wdata;
          wr_d = (i_cmd_op == OP_WRITE) || (i_cmd_op == OP_CMD);
          if (i_cmd_op == OP_CMD) begin
            addr_d = {{(ADDR_W - CMD_ADDR_BITS){1'b0}},
                      i_cmd_addr[CMD_ADDR_BITS-1:0]};
            wdata_d = {{(DATA_W - CMD_DATA_BITS){1'b0}},
                       i_cmd_wdata[CMD_DATA_BITS-1:0]};
          end
          if (i_cmd_op == OP_ID_READ) begin
            addr_d = '0;
            addr_d[ID_SELECT_ADDR_BIT] = i_cmd_addr[ID_SELECT_ADDR_BIT];
          end
          req_d = 1'b1;
          ready_d = 1'b0;
          first_d = 1'b1;
          tout_d = 1'b0;
          stog_d = 1'b0;
          tmr_d = '0;
          st_d = M_BUSY;
        end
      end
      M_BUSY: begin
        if (tmr_q != 32'hFFFF_FFFF) begin
          tmr_d = tmr_q + 1'b1;
        end
        if (cyc.ack) begin
          rdata_d = cyc.rdata;
          prev_d = cyc.rdata;
          first_d = 1'b0;
          if (!first_q) begin
            // Suspended erase sector: bit 6 stays, bit 2 still moves
            stog_d = cyc.rdata[ERASE_SECTOR_TOGGLE_BIT] !=
                     prev_q[ERASE_SECTOR_TOGGLE_BIT];
          end
          if ((op_q == OP_TOGGLE_POLL || op_q == OP_DATA_POLL) && !settled &&
              tmr_q < 32'(POLL_LIMIT)) begin
            // Same address stays on the bus for the next poll read
            req_d = 1'b1;
          end else begin
            tout_d = (op_q == OP_TOGGLE_POLL || op_q == OP_DATA_POLL) && !settled;
            req_d = 1'b0;
            done_d = 1'b1;
            ready_d = 1'b1;
            st_d = M_IDLE;
          end
        end
      end
      default: st_d = M_RST;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= M_RST;
      tmr_q <= '0;
      op_q <= OP_READ;
      addr_q <= '0;
      wdata_q <= '0;
      prev_q <= '0;
      rdata_q <= '0;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      first_q <= 1'b0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      tout_q <= 1'b0;
      stog_q <= 1'b0;
      frst_n_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      op_q <= op_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      prev_q <= prev_d;
      rdata_q <= rdata_d;
      req_q <= req_d;
      wr_q <= wr_d;
      first_q <= first_d;
      ready_q <= ready_d;
      done_q <= done_d;
      tout_q <= tout_d;
      stog_q <= stog_d;
      frst_n_q <= frst_n_d;
    end
  end

  assign o_cmd_ready = ready_q;
  assign o_done = done_q;
  assign o_timeout = tout_q;
  assign o_sector_toggled = stog_q;
  assign o_rdata = rdata_q;
  assign o_flash_reset_n = frst_n_q;
endmodule
`default_nettype wire
